/* File: rtl/pcsv_defines.svh */
// shared constants of the receive status vector block: offsets, fields, resets
// assumes a single pclk domain and a 32-bit apb register bus
//
// Summary of operation
// - link bit high after sync and negotiation
// - link bit low on sync loss or failure
// - negotiating: link bit follows link register
// - not negotiating: link bit copies sync bit
// - sync bit from code group sync machine
// - sync bit high while sync is ok
// - bit 2 while configuration sets arrive
// - bit 3 while idle sets arrive
// - flag invalid data inside ordered sets
// - all outputs synchronous to core clock
`ifndef PCSV_DEFINES_SVH
`define PCSV_DEFINES_SVH

// ==================================================================
// register offsets (byte addresses)
`define PCSV_OFS_CTRL       8'h00
`define PCSV_OFS_LINK       8'h04
`define PCSV_OFS_IRQ_STAT   8'h08
`define PCSV_OFS_IRQ_MASK   8'h0c
`define PCSV_OFS_VECTOR     8'h10

// ==================================================================
// field positions
`define PCSV_CTRL_AN_EN     0
`define PCSV_LINK_STATUS    2
`define PCSV_LINK_AN_DONE   5
`define PCSV_VEC_LINK       0
`define PCSV_VEC_SYNC       1
`define PCSV_VEC_CFG_SETS   2
`define PCSV_VEC_IDLE_SETS  3
`define PCSV_VEC_INVALID    4
`define PCSV_VEC_DISP       5
`define PCSV_EV_SYNC_UP     0
`define PCSV_EV_SYNC_DOWN   1
`define PCSV_EV_INVALID     2
`define PCSV_EV_DISP        3
`define PCSV_EV_LINK_CHG    4

// ==================================================================
// reset values
`define PCSV_CTRL_RESET     1'b0
`define PCSV_MASK_RESET     5'h00

// ==================================================================
// code group values and sync thresholds
`define PCSV_K28_5          8'hbc
`define PCSV_D21_5          8'hb5
`define PCSV_D2_2           8'h42
`define PCSV_D5_6           8'hc5
`define PCSV_D16_2          8'h50
`define PCSV_GOOD_RUN       2'h3
`define PCSV_ERR_LIMIT      3'h4

`endif

/* File: rtl/pcsv_pkg.sv */
// types shared by the receive status vector block
// assumes the defines header is compiled alongside
package pcsv_pkg;

    // ==================================================================
    // synchronisation machine, gray coded along the acquire path
    typedef enum logic [2:0] {
        PCSV_LOSS = 3'h0,
        PCSV_CD1  = 3'h1,
        PCSV_AQ1  = 3'h3,
        PCSV_CD2  = 3'h2,
        PCSV_AQ2  = 3'h6,
        PCSV_CD3  = 3'h7,
        PCSV_SYNC = 3'h5
    } pcsv_sync_t;

    // ==================================================================
    // ordered set decoder position
    typedef enum logic [2:0] {
        PCSV_OS_NONE = 3'h0,
        PCSV_OS_K    = 3'h1,
        PCSV_OS_C1   = 3'h3,
        PCSV_OS_C2   = 3'h2,
        PCSV_OS_I    = 3'h6
    } pcsv_os_t;

endpackage

/* File: rtl/pcsv_sync_fsm.sv */
// code group synchronisation state machine
// assumes one code group per rx_cg_valid pulse, already decoded, on pclk
`include "pcsv_defines.svh"

module pcsv_sync_fsm (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // decoded code groups
    input  wire logic               cg_valid,
    input  wire logic               cg_comma,
    input  wire logic               cg_bad,
    // result
    output pcsv_pkg::pcsv_sync_t    state,
    output logic                    sync_ok
);
    import pcsv_pkg::*;

    pcsv_sync_t   next_state;
    logic [2:0]   err_cnt;
    logic [1:0]   good_cnt;

    // ==================================================================
    // next state: three commas separated by clean data acquire sync
    always_comb begin
        next_state = state;
        if (cg_valid) begin
            case (state)
                PCSV_LOSS: next_state = (cg_comma && !cg_bad) ? PCSV_CD1 : PCSV_LOSS;
                PCSV_CD1:  next_state = cg_bad ? PCSV_LOSS : (cg_comma ? PCSV_CD1 : PCSV_AQ1);
                PCSV_AQ1:  next_state = cg_bad ? PCSV_LOSS : (cg_comma ? PCSV_CD2 : PCSV_AQ1);
                PCSV_CD2:  next_state = cg_bad ? PCSV_LOSS : (cg_comma ? PCSV_CD2 : PCSV_AQ2);
                PCSV_AQ2:  next_state = cg_bad ? PCSV_LOSS : (cg_comma ? PCSV_CD3 : PCSV_AQ2);
                PCSV_CD3:  next_state = cg_bad ? PCSV_LOSS : (cg_comma ? PCSV_CD3 : PCSV_SYNC);
                PCSV_SYNC: next_state = (cg_bad && err_cnt == `PCSV_ERR_LIMIT - 3'h1) ? PCSV_LOSS : PCSV_SYNC;
                default:   next_state = PCSV_LOSS;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PCSV_LOSS;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================================
    // error budget: each run of good groups forgives one bad group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt  <= 3'h0;
            good_cnt <= 2'h0;
        end else if (state != PCSV_SYNC) begin
            err_cnt  <= 3'h0;
            good_cnt <= 2'h0;
        end else if (cg_valid && cg_bad) begin
            err_cnt  <= err_cnt + 3'h1;
            good_cnt <= 2'h0;
        end else if (cg_valid && err_cnt != 3'h0) begin
            if (good_cnt == `PCSV_GOOD_RUN) begin
                err_cnt  <= err_cnt - 3'h1;
                good_cnt <= 2'h0;
            end else begin
                good_cnt <= good_cnt + 2'h1;
            end
        end
    end

    // registered so the status word never sees a glitch of the decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ok <= 1'b0;
        end else begin
            sync_ok <= (next_state == PCSV_SYNC);
        end
    end

endmodule

/* File: rtl/pcsv_status.sv */
// receive status vector: sync, ordered set and error status of one channel
// assumes decoded code groups and negotiation result synchronous to pclk,
// and an apb master on the same clock
//
// The APB register port and the register addresses were chosen for this implementation.
`include "pcsv_defines.svh"

module pcsv_status (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // decoded receive code groups
    input  wire logic          rx_cg_valid,
    input  wire logic [7:0]    rx_cg_data,
    input  wire logic          rx_cg_is_k,
    input  wire logic          rx_cg_not_in_table,
    input  wire logic          rx_running_disparity_fault,
    // negotiation engine
    input  wire logic          an_complete,
    // status to client logic
    output logic      [5:0]    status_vector,
    output logic               irq
);
    import pcsv_pkg::*;

    // ==================================================================
    // declarations
    pcsv_sync_t   sync_state;
    logic         sync_ok;
    logic         cg_comma;
    logic         cg_bad;
    pcsv_os_t     os_pos;
    pcsv_os_t     next_os_pos;
    logic         os_c_done;
    logic         os_i_done;
    logic         os_break;
    logic         rx_config_sets_seen;
    logic         rx_idle_sets_seen;
    logic         rx_invalid_in_set;
    logic         disp_seen;
    logic         an_enable;
    logic         link_reg_status;
    logic         next_link;
    logic         link_q;
    logic         sync_q;
    logic [4:0]   events;
    logic [4:0]   irq_stat;
    logic [4:0]   irq_mask;
    logic         apb_setup_ok;
    logic         apb_done;
    logic         apb_rd_take;
    logic         addr_hit;
    logic [31:0]  rd_mux;
    logic         stat_rd_clr;

    // ==================================================================
    // code group classification
    // a bad group is one outside the tables or with a disparity fault
    assign cg_comma = rx_cg_is_k && (rx_cg_data == `PCSV_K28_5);
    assign cg_bad   = rx_cg_not_in_table || rx_running_disparity_fault;

    // ==================================================================
    // synchronisation machine
    pcsv_sync_fsm u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .cg_valid (rx_cg_valid),
        .cg_comma (cg_comma),
        .cg_bad   (cg_bad),
        .state    (sync_state),
        .sync_ok  (sync_ok)
    );

    // ==================================================================
    // ordered set tracking
    // /C/ is comma, D21.5 or D2.2, then two config bytes; /I/ is comma and
    // D5.6 or D16.2. a set counts only when all of its groups arrive clean.
    always_comb begin
        next_os_pos = os_pos;
        os_c_done   = 1'b0;
        os_i_done   = 1'b0;
        os_break    = 1'b0;
        if (rx_cg_valid) begin
            if (cg_bad) begin
                next_os_pos = PCSV_OS_NONE;
                os_break    = (os_pos != PCSV_OS_NONE);
            end else if (cg_comma) begin
                next_os_pos = PCSV_OS_K;
                os_break    = (os_pos == PCSV_OS_C1) || (os_pos == PCSV_OS_C2);
            end else begin
                case (os_pos)
                    PCSV_OS_K: begin
                        if (!rx_cg_is_k && (rx_cg_data == `PCSV_D21_5 || rx_cg_data == `PCSV_D2_2)) begin
                            next_os_pos = PCSV_OS_C1;
                        end else if (!rx_cg_is_k && (rx_cg_data == `PCSV_D5_6 || rx_cg_data == `PCSV_D16_2)) begin
                            next_os_pos = PCSV_OS_NONE;
                            os_i_done   = 1'b1;
                        end else begin
                            next_os_pos = PCSV_OS_NONE;
                            os_break    = 1'b1;
                        end
                    end
                    PCSV_OS_C1: begin
                        next_os_pos = rx_cg_is_k ? PCSV_OS_NONE : PCSV_OS_C2;
                        os_break    = rx_cg_is_k;
                    end
                    PCSV_OS_C2: begin
                        next_os_pos = PCSV_OS_NONE;
                        os_c_done   = !rx_cg_is_k;
                        os_break    = rx_cg_is_k;
                    end
                    default: begin
                        next_os_pos = PCSV_OS_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_pos <= PCSV_OS_NONE;
        end else if (!sync_ok) begin
            os_pos <= PCSV_OS_NONE;
        end else begin
            os_pos <= next_os_pos;
        end
    end

    // ==================================================================
    // set indications: hold while that kind of set keeps arriving
    // sets are only believed while synchronised; out of sync they drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_config_sets_seen <= 1'b0;
        end else if (!sync_ok || os_i_done || os_break) begin
            rx_config_sets_seen <= 1'b0;
        end else if (os_c_done) begin
            rx_config_sets_seen <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_idle_sets_seen <= 1'b0;
        end else if (!sync_ok || os_c_done || os_break) begin
            rx_idle_sets_seen <= 1'b0;
        end else if (os_i_done) begin
            rx_idle_sets_seen <= 1'b1;
        end
    end

    // invalid flag stays up until the next complete clean set or sync loss
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_invalid_in_set <= 1'b0;
        end else if (sync_ok && os_break) begin
            rx_invalid_in_set <= 1'b1;
        end else if (!sync_ok || os_c_done || os_i_done) begin
            rx_invalid_in_set <= 1'b0;
        end
    end

    // disparity fault reported per received group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_seen <= 1'b0;
        end else if (rx_cg_valid) begin
            disp_seen <= rx_running_disparity_fault;
        end
    end

    // ==================================================================
    // link status
    // the link register bit mirrors a management status register bit 2
    assign link_reg_status = sync_ok && an_complete;
    always_comb begin
        if (an_enable) begin
            next_link = link_reg_status;
        end else begin
            next_link = sync_ok;
        end
    end

    // ==================================================================
    // status vector, one flop per bit on the core clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_vector <= 6'h00;
        end else begin
            status_vector[`PCSV_VEC_LINK]      <= next_link;
            status_vector[`PCSV_VEC_SYNC]      <= sync_ok;
            status_vector[`PCSV_VEC_CFG_SETS]  <= rx_config_sets_seen;
            status_vector[`PCSV_VEC_IDLE_SETS] <= rx_idle_sets_seen;
            status_vector[`PCSV_VEC_INVALID]   <= rx_invalid_in_set;
            status_vector[`PCSV_VEC_DISP]      <= disp_seen;
        end
    end

    // ==================================================================
    // event detection for the interrupt status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            link_q <= next_link;
            sync_q <= sync_ok;
        end
    end

    always_comb begin
        events                      = 5'h00;
        events[`PCSV_EV_SYNC_UP]    = sync_ok && !sync_q;
        events[`PCSV_EV_SYNC_DOWN]  = !sync_ok && sync_q;
        events[`PCSV_EV_INVALID]    = sync_ok && os_break;
        events[`PCSV_EV_DISP]       = rx_cg_valid && rx_running_disparity_fault;
        events[`PCSV_EV_LINK_CHG]   = next_link != link_q;
    end

    // ==================================================================
    // apb handshake
    // one wait state lets read data and pready both come from flops
    assign apb_setup_ok = psel && penable && !pready;
    assign apb_done     = psel && penable && pready;
    assign apb_rd_take  = apb_setup_ok && !pwrite;

    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        case (paddr)
            `PCSV_OFS_CTRL: begin
                rd_mux[`PCSV_CTRL_AN_EN] = an_enable;
            end
            `PCSV_OFS_LINK: begin
                rd_mux[`PCSV_LINK_STATUS]  = link_reg_status;
                rd_mux[`PCSV_LINK_AN_DONE] = an_complete;
            end
            `PCSV_OFS_IRQ_STAT: begin
                rd_mux[4:0] = irq_stat;
            end
            `PCSV_OFS_IRQ_MASK: begin
                rd_mux[4:0] = irq_mask;
            end
            `PCSV_OFS_VECTOR: begin
                rd_mux[5:0] = status_vector;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup_ok;
            pslverr <= apb_setup_ok && !addr_hit;
            if (apb_rd_take) begin
                prdata <= rd_mux;
            end
        end
    end

    // ==================================================================
    // writable registers, committed at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_enable <= `PCSV_CTRL_RESET;
        end else if (apb_done && pwrite && paddr == `PCSV_OFS_CTRL) begin
            an_enable <= pwdata[`PCSV_CTRL_AN_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `PCSV_MASK_RESET;
        end else if (apb_done && pwrite && paddr == `PCSV_OFS_IRQ_MASK) begin
            irq_mask <= pwdata[4:0];
        end
    end

    // ==================================================================
    // sticky interrupt status, cleared by the read that samples it
    // an event in the clearing cycle survives, since set wins over clear
    assign stat_rd_clr = apb_rd_take && paddr == `PCSV_OFS_IRQ_STAT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 5'h00;
        end else begin
            irq_stat <= (irq_stat & {5{!stat_rd_clr}}) | events;
        end
    end

    // interrupt level: updates on the same edge as the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat & {5{!stat_rd_clr}}) | events) & irq_mask);
        end
    end

endmodule

/* File: tb/pcsv_status_properties.sv */
// checker for the receive status vector ports of pcsv_status
// assumes one pclk domain and the active-low asynchronous presetn
module pcsv_status_properties (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // apb answer
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // code groups
    input wire logic       rx_cg_valid,
    input wire logic       rx_cg_is_k,
    input wire logic       rx_running_disparity_fault,
    input wire logic       an_complete,
    // status
    input wire logic [5:0] status_vector,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_link_needs_sync: assert property (status_vector[0] |-> status_vector[1])
        else $error("link bit high without sync");
    // once the negotiation result has been steady a cycle, link equals sync
    chk_link_equals_sync: assert property ($past(an_complete) |-> status_vector[0] == status_vector[1])
        else $error("link bit differs from sync bit");
    // two cycles out of sync leave no set flags behind
    chk_sets_need_sync: assert property (!status_vector[1] && !$past(status_vector[1])
        |-> status_vector[4:2] == 3'h0)
        else $error("set flags while unsynchronised");
    chk_cfg_idle_excl: assert property (!(status_vector[2] && status_vector[3]))
        else $error("config and idle flags together");
    chk_disp_tracks: assert property (rx_cg_valid |-> ##2 status_vector[5] == $past(rx_running_disparity_fault, 2))
        else $error("disparity bit wrong");
    // sync only rises on a data group taken two edges before
    chk_sync_after_data: assert property ($rose(status_vector[1])
        |-> $past(rx_cg_valid, 2) && !$past(rx_cg_is_k, 2))
        else $error("sync rose without data group");
    chk_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not after one wait");
    chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside answer cycle");

    cov_sync_up: cover property ($rose(status_vector[1]));
    cov_cfg_seen: cover property ($rose(status_vector[2]));
    cov_invalid: cover property ($rose(status_vector[4]));
    cov_irq: cover property ($rose(irq));
endmodule

bind pcsv_status pcsv_status_properties chk_u (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .rx_cg_valid                (rx_cg_valid),
    .rx_cg_is_k                 (rx_cg_is_k),
    .rx_running_disparity_fault (rx_running_disparity_fault),
    .an_complete                (an_complete),
    .status_vector              (status_vector),
    .irq                        (irq)
);

/* File: tb/pcsv_link_peer.sv */
// remote transmitter model: hands decoded code groups to the status block
// assumes groups are taken on rising pclk edges while rx_cg_valid is high
`include "pcsv_defines.svh"

module pcsv_link_peer (
    // clock
    input  wire logic       pclk,
    // decoded code groups
    output logic            rx_cg_valid,
    output logic [7:0]      rx_cg_data,
    output logic            rx_cg_is_k,
    output logic            rx_cg_not_in_table,
    output logic            rx_running_disparity_fault
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // quiet line at time zero
    initial begin
        rx_cg_valid = 1'b0;
        rx_cg_data = 8'h00;
        rx_cg_is_k = 1'b0;
        rx_cg_not_in_table = 1'b0;
        rx_running_disparity_fault = 1'b0;
    end

    // one group per edge; the flags qualify only the group they travel with
    task automatic send(input logic k, input logic [7:0] d, input logic bad, input logic disp);
        @(posedge pclk);
        rx_cg_valid <= 1'b1;
        rx_cg_data <= d;
        rx_cg_is_k <= k;
        rx_cg_not_in_table <= bad;
        rx_running_disparity_fault <= disp;
    endtask

    // the byte lane flips when idle so a stale byte never looks like a group
    task automatic rest();
        @(posedge pclk);
        rx_cg_valid <= 1'b0;
        rx_cg_data <= ~rx_cg_data;
    endtask

    task automatic idle_sets(input int n);
        repeat (n) begin
            send(1'b1, `PCSV_K28_5, 1'b0, 1'b0);
            send(1'b0, `PCSV_D16_2, 1'b0, 1'b0);
        end
    endtask

    task automatic cfg_sets(input int n);
        repeat (n) begin
            send(1'b1, `PCSV_K28_5, 1'b0, 1'b0);
            send(1'b0, `PCSV_D21_5, 1'b0, 1'b0);
            send(1'b0, 8'h01, 1'b0, 1'b0);
            send(1'b0, 8'h00, 1'b0, 1'b0);
        end
    endtask
endmodule

/* File: tb/pcsv_receive_status_vector_tb.sv */
// self-checking bench for pcsv_status: apb master, code group peer, checks
// assumes one 100 MHz pclk and the one-wait-state apb answer
`include "pcsv_defines.svh"

module pcsv_receive_status_vector_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        rx_cg_valid, rx_cg_is_k, rx_cg_not_in_table, rx_running_disparity_fault;
    logic        an_complete, irq;
    logic [7:0]  paddr, rx_cg_data;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  status_vector;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    // ==================================================================
    // design and peer
    pcsv_status dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_cg_valid(rx_cg_valid), .rx_cg_data(rx_cg_data), .rx_cg_is_k(rx_cg_is_k),
        .rx_cg_not_in_table(rx_cg_not_in_table),
        .rx_running_disparity_fault(rx_running_disparity_fault),
        .an_complete(an_complete), .status_vector(status_vector), .irq(irq)
    );
    pcsv_link_peer peer_u (
        .pclk(pclk), .rx_cg_valid(rx_cg_valid), .rx_cg_data(rx_cg_data), .rx_cg_is_k(rx_cg_is_k),
        .rx_cg_not_in_table(rx_cg_not_in_table),
        .rx_running_disparity_fault(rx_running_disparity_fault)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==================================================================
    // report, compare and bus tasks
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // request held until pready is sampled high; data and error taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // status bits are levels: stop the line, let two edges of latency pass
    task automatic vec(input logic [5:0] exp, input logic [5:0] msk, input string what);
        peer_u.rest();
        repeat (3) @(posedge pclk);
        chk_word({26'h0, status_vector & msk}, {26'h0, exp & msk}, what);
    endtask

    // hang guard well above the roughly 140 cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    // ==================================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        an_complete = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        vec(6'h00, 6'h3f, "reset vector");
        chk_word({31'h0, irq}, 32'h0, "reset irq");
        apb(1'b0, `PCSV_OFS_CTRL, 32'h0);
        chk_word(rd, 32'h0, "ctrl reset");
        apb(1'b0, `PCSV_OFS_IRQ_MASK, 32'h0);
        chk_word(rd, 32'h0, "mask reset");
        apb(1'b1, 8'h14, 32'h1);
        chk_word({31'h0, err}, 32'h1, "unmapped write");
        apb(1'b0, 8'h14, 32'h0);
        chk_word({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        // acquire sync on idles, negotiation off: link copies sync
        peer_u.idle_sets(5);
        vec(6'h0b, 6'h3f, "sync on idles");
        chk_word({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, `PCSV_OFS_IRQ_MASK, 32'h1f);
        repeat (2) @(posedge pclk);
        chk_word({31'h0, irq}, 32'h1, "unmasked irq");
        apb(1'b0, `PCSV_OFS_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h11, "sync up and link events");
        repeat (2) @(posedge pclk);
        chk_word({31'h0, irq}, 32'h0, "irq cleared by read");
        // configuration sets replace idles
        peer_u.cfg_sets(2);
        vec(6'h07, 6'h3f, "config sets");
        // unknown byte after a comma breaks the set, a full idle heals it
        peer_u.send(1'b1, `PCSV_K28_5, 1'b0, 1'b0);
        peer_u.send(1'b0, 8'h00, 1'b0, 1'b0);
        vec(6'h13, 6'h3f, "broken set");
        peer_u.idle_sets(1);
        vec(6'h0b, 6'h3f, "idle after broken set");
        // a single disparity fault shows, sync survives, next good group clears
        peer_u.send(1'b0, `PCSV_D16_2, 1'b0, 1'b1);
        vec(6'h22, 6'h22, "disparity fault");
        peer_u.idle_sets(2);
        vec(6'h0b, 6'h3f, "disparity cleared");
        // negotiation enabled but not complete holds the link bit low
        apb(1'b1, `PCSV_OFS_CTRL, 32'h1);
        vec(6'h0a, 6'h3f, "link gated by negotiation");
        apb(1'b0, `PCSV_OFS_LINK, 32'h0);
        chk_word(rd, 32'h0, "link reg down");
        an_complete <= 1'b1;
        vec(6'h0b, 6'h3f, "link after negotiation");
        apb(1'b0, `PCSV_OFS_VECTOR, 32'h0);
        chk_word(rd, 32'h0b, "vector reg");
        apb(1'b0, `PCSV_OFS_LINK, 32'h0);
        chk_word(rd, 32'h24, "link reg up");
        apb(1'b0, `PCSV_OFS_IRQ_STAT, 32'h0);
        chk_word(rd, 32'h1c, "invalid disparity link events");
        // a comma then bad groups break a set, drop sync and every dependent bit
        peer_u.send(1'b1, `PCSV_K28_5, 1'b0, 1'b0);
        repeat (4) begin
            peer_u.send(1'b0, 8'h00, 1'b1, 1'b0);
        end
        vec(6'h00, 6'h3f, "sync lost");
        apb(1'b0, `PCSV_OFS_IRQ_STAT, 32'h0);
        chk_word(rd & 32'h12, 32'h12, "sync down event");
        stop_test();
    end
endmodule
